// [include/csd_pkg.sv]
// How it works
// - four selects, each with its own base and mask register pair, programmed independently.
// - the base register holds the block start address in 256-byte steps (address bits 31..8).
// - a valid flag in the base register must be set before a select uses its settings.
// - the mask register sets a power-of-two block size from 256 bytes to 4 Gbytes.
// - a port-width field picks an 8-bit port (data 15..8, odd and even) or a 16-bit port.
// - with write protect set, a select refuses writes to its range.
// - with fast termination set, the acknowledge comes early for a two-cycle access.
// - the acknowledge is made internally with zero to three wait states from the delay field.
// - address bits 31..8 and the space code, qualified by its mask, are compared.
// - after reset select zero asserts for every address until its valid flag is set.
// - in global mode select zero is a 16-bit port, three waits, no write protect, all spaces.
// - select zero keeps decoding every address while a range is loaded into its base register before validation.
// - once select zero is validated, global mode returns only through reset.
package csd_pkg;
  localparam int NUM_SEL = 4;
  localparam logic [7:0] OFF_BASE0 = 8'h00;
  localparam logic [7:0] OFF_MASK0 = 8'h04;
  localparam int  REG_STRIDE_SH = 3;
  localparam int  ADDR_LSB_CMP = 8;
  localparam int  BIT_VALID = 0;
  localparam int  BIT_WP = 1;
  localparam int  BIT_FTE = 2;
  localparam int  FC_LSB = 4;
  localparam int  FC_W = 3;
  localparam int  PS_BIT = 1;
  localparam int  DD_LSB = 2;
  localparam int  DD_W = 2;
  localparam logic [1:0] GLOBAL_WAITS = 2'h3;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  localparam logic [2:0]  FTE_WAITS = 3'h0;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic [2:0]  fc;
    logic        write;
  } csd_cyc_s;

  typedef enum logic [1:0] {
    CSD_IDLE = 2'b00,
    CSD_WAIT = 2'b01,
    CSD_ACK  = 2'b11,
    CSD_DONE = 2'b10
  } csd_state_e;
endpackage

// [verification/chip_select_decoder_test.sv]
`timescale 1ns/10ps
module chip_select_decoder_test;
  import csd_pkg::*;
  logic clk_in, reset_in, psel, pen, pwr, pready, pslv, perr, cend, ack;
  logic p16, p16s, wref, wseen, gmode, own8;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] sel_n, selm;
  logic [15:0] res;
  csd_cyc_s cyc;
  int error_cnt, compares, lat, rel;
  chip_select_decoder #(.NSEL(4)) i_chip_select_decoder (.clk_in(clk_in), .reset_in(reset_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslv), .cyc_in(cyc),
    .cyc_end_in(cend), .select_n_out(sel_n), .cycle_ack_internal_out(ack), .port16_out(p16),
    .write_refused_out(wref), .global_mode_out(gmode));
  csd_mem_model i_csd_mem_model (.clk_in(clk_in), .reset_in(reset_in), .select_n_in(sel_n),
    .ack_in(ack), .own8_in(own8), .end_out(cend));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("mismatches %0d comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bail;
    error_cnt++;
    results();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_in) pen <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (i == 8) bail();
    rv = prdata;
    perr = pslv;
    {psel, pen} <= 2'b00;
    @(posedge clk_in);
  endtask
  // result nibbles: select mask, port16 and refusal, ack waits, release cycle
  task automatic bus(input logic [31:0] a, input logic [2:0] f, input logic w);
    int n;
    {selm, p16s, wseen, lat, rel} = {6'h0, -32'sd1, -32'sd1};
    cyc <= '{1'b1, a, f, w};
    for (n = 1; n < 12 && rel < 0; n++) begin
      @(posedge clk_in);
      if (cend === 1'b1) cyc.req <= 1'b0;
      #1;
      wseen |= wref;
      if (ack === 1'b1 && lat < 0) lat = n - 2;
      if (selm !== 4'h0 && sel_n === 4'hF) rel = n;
      if (selm === 4'h0 && sel_n !== 4'hF) {selm, p16s} = {~sel_n, p16};
    end
    if (selm !== 4'h0 && rel < 0) bail();
    res = {selm, 2'b00, p16s, wseen, lat[3:0], rel[3:0]};
    @(posedge clk_in) cyc.req <= 1'b0;
    @(posedge clk_in);
  endtask
  initial begin
    reset_in = 1'b1;
    cyc = '0;
    {psel, pen, pwr, own8, paddr, pwdata} = '0;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk("global", 1, gmode);
    apb(1'b0, 8'h00, 32'h0);
    chk("base0", BASE_RESET, rv);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 1, perr);
    $display("test reset ended");
    for (int f = 0; f < 8; f++) begin
      bus(32'h0000_0004 + f, 3'(f), f[0]);
      chk("boot", {8'h12, 4'(GLOBAL_WAITS), 4'(GLOBAL_WAITS + 4)}, res);
    end
    apb(1'b1, 8'h08, 32'h0001_0051);
    apb(1'b1, 8'h0C, 32'h0000_0F08);
    apb(1'b1, 8'h04, 32'h000F_FF7E);
    apb(1'b1, 8'h00, 32'h0020_0004);
    apb(1'b0, 8'h08, 32'h0);
    chk("base1", 32'h0001_0051, rv);
    chk("stay", 1, gmode);
    apb(1'b1, 8'h00, 32'h0020_0005);
    @(posedge clk_in);
    chk("left", 0, gmode);
    bus(32'h0020_1234, 3'h1, 1'b0);
    chk("fast", 16'h1204, res);
    bus(32'h0001_0A00, 3'h5, 1'b0);
    chk("sel1", 16'h2026, res);
    bus(32'h0001_0A00, 3'h6, 1'b0);
    chk("space", 16'h00FF, res);
    bus(32'h0001_1000, 3'h5, 1'b0);
    chk("size", 16'h00FF, res);
    $display("test decode ended");
    apb(1'b1, 8'h08, 32'h0001_0053);
    bus(32'h0001_0A00, 3'h5, 1'b1);
    chk("protect", 16'h01FF, res);
    apb(1'b1, 8'h0C, 32'h0000_0F0C);
    own8 <= 1'b1;
    bus(32'h0001_0A00, 3'h5, 1'b0);
    chk("own8", 16'h20F5, res);
    own8 <= 1'b0;
    apb(1'b1, 8'h00, 32'h0020_0004);
    chk("noboot", 0, gmode);
    bus(32'h0020_1234, 3'h1, 1'b0);
    chk("invalid", 16'h00FF, res);
    $display("test protect ended");
    reset_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk("reboot", 1, gmode);
    bus(32'h0000_0000, 3'h7, 1'b1);
    chk("rboot", {8'h12, 4'(GLOBAL_WAITS), 4'(GLOBAL_WAITS + 4)}, res);
    $display("test reboot ended");
    results();
  end
endmodule // chip_select_decoder_test

// [verification/csd_mem_model.sv]
`timescale 1ns/10ps
module csd_mem_model (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic [3:0] select_n_in,
  input wire logic       ack_in,
  input wire logic       own8_in,
  output logic           end_out
);
  logic [2:0] cnt_q;
  // own8 ends the cycle after two waits, ahead of the internal ack
  always_ff @(posedge clk_in) begin
    if (reset_in || &select_n_in || end_out) begin
      cnt_q <= 3'h0;
      end_out <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      end_out <= own8_in ? cnt_q == 3'h2 : ack_in;
    end
  end
endmodule // csd_mem_model

// [verification/csd_sva.sv]
`timescale 1ns/10ps
module csd_sva #(parameter int NSEL = 4) (
  input wire logic              clk_in,
  input wire logic              reset_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pready_out,
  input wire csd_pkg::csd_cyc_s cyc_in,
  input wire logic              cyc_end_in,
  input wire logic [NSEL-1:0]   select_n_out,
  input wire logic              cycle_ack_internal_out,
  input wire logic              port16_out,
  input wire logic              write_refused_out,
  input wire logic              global_mode_out
);
  import csd_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // the bench holds req low between cycles, so a rise is a take
  sequence s_gtake; $rose(cyc_in.req) && global_mode_out; endsequence
  sequence s_gack; !cycle_ack_internal_out [*4] ##1 cycle_ack_internal_out; endsequence
  AST_RST: assert property ($fell(reset_in) |-> global_mode_out && &select_n_out)
    else $error("bad reset state");
  AST_APB: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("no ready");
  AST_GSEL: assert property (s_gtake |=> !select_n_out[0] && port16_out)
    else $error("no boot select");
  AST_GACK: assert property (s_gtake |=> s_gack)
    else $error("boot ack time");
  AST_END: assert property (cyc_end_in |=> &select_n_out)
    else $error("select held");
  AST_KEEP: assert property (!global_mode_out |=> !global_mode_out)
    else $error("boot mode back");
  AST_WP: assert property (write_refused_out |-> &select_n_out)
    else $error("refused but selected");
  AST_ONE: assert property ($onehot0(~select_n_out))
    else $error("two selects");
  AST_PULSE: assert property (cycle_ack_internal_out |=> !cycle_ack_internal_out)
    else $error("ack held");
  AST_ACKSEL: assert property (cycle_ack_internal_out |-> !(&select_n_out))
    else $error("ack without select");
endmodule // csd_sva
bind chip_select_decoder csd_sva #(.NSEL(NSEL)) i_csd_sva (.*);

// [verilog/chip_select_decoder.sv]
`timescale 1ns/10ps
module chip_select_decoder #(
  parameter int NSEL = 4
) (
  input  wire logic                     clk_in,
  input  wire logic                     reset_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [7:0]               paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic [31:0]                   prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  input  wire csd_pkg::csd_cyc_s        cyc_in,
  input  wire logic                     cyc_end_in,
  output logic [NSEL-1:0]               select_n_out,
  output logic                          cycle_ack_internal_out,
  output logic                          port16_out,
  output logic                          write_refused_out,
  output logic                          global_mode_out
);
  import csd_pkg::*;

  logic [31:0]     base_q [NSEL];
  logic [31:0]     mask_q [NSEL];
  logic            global_q;
  csd_state_e      st_q;
  logic [NSEL-1:0] sel_n_q;
  logic            port16_q;
  logic            refused_q;
  logic [31:0]     prdata_q;
  logic            pready_q;
  logic            pslverr_q;

  wire [NSEL-1:0] hit;
  wire [NSEL-1:0] refuse;
  wire [NSEL-1:0] wr_base;
  wire [NSEL-1:0] wr_mask;
  wire            apb_setup;
  wire            mapped;
  wire [1:0]      reg_idx;
  wire            reg_is_mask;
  wire [31:0]     rd_word;
  wire            start;
  wire            wg_ack;
  wire [NSEL-1:0] hit_eff;
  wire            any_hit;
  wire            any_refuse;
  wire [NSEL-1:0] pick;
  wire [2:0]      waits_sel;
  wire            ps16_sel;
  wire            apb_done;
  wire            wg_clr;

  // apb: one wait state, every access answered in the second access cycle
  assign apb_setup   = psel_in && penable_in && !pready_q;
  // writes land only at the edge where the master sees pready high
  assign apb_done    = psel_in && penable_in && pready_q;
  assign reg_idx     = paddr_in[REG_STRIDE_SH +: 2];
  assign reg_is_mask = paddr_in[2];
  assign mapped      = (paddr_in[1:0] == 2'h0) && (paddr_in[7:5] == 3'h0);
  assign rd_word     = !mapped ? RD_UNMAPPED :
                       reg_is_mask ? mask_q[reg_idx] : base_q[reg_idx];

  genvar g;
  generate
    for (g = 0; g < NSEL; g++) begin : g_sel
      csd_match u_match (
        .base_in    (base_q[g]),
        .mask_in    (mask_q[g]),
        .cyc_in     (cyc_in),
        .hit_out    (hit[g]),
        .refuse_out (refuse[g])
      );
      assign wr_base[g] = apb_done && pwrite_in && mapped && !reg_is_mask &&
                          (reg_idx == 2'(g));
      assign wr_mask[g] = apb_done && pwrite_in && mapped && reg_is_mask &&
                          (reg_idx == 2'(g));
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          base_q[g] <= BASE_RESET;
          mask_q[g] <= MASK_RESET;
        end else begin
          if (wr_base[g]) base_q[g] <= pwdata_in;
          if (wr_mask[g]) mask_q[g] <= pwdata_in;
        end
      end
    end
  endgenerate

  // global mode: select zero takes every address, all spaces, no protection
  assign hit_eff    = global_q ? {{(NSEL-1){1'b0}}, 1'b1} : hit;
  assign any_hit    = |hit_eff;
  // lowest numbered select wins on overlap; overlapping ranges are a software error
  assign pick       = hit_eff & (~hit_eff + {{(NSEL-1){1'b0}}, 1'b1});
  assign any_refuse = global_q ? 1'b0 : |(refuse & pick);
  assign waits_sel  = global_q ? {1'b0, GLOBAL_WAITS} : waits_of(pick);
  assign ps16_sel   = global_q ? 1'b1 : ps_of(pick);
  assign start      = (st_q == CSD_IDLE) && cyc_in.req && any_hit && !any_refuse;

  function automatic logic [2:0] waits_of(input logic [NSEL-1:0] p);
    logic [2:0] w;
    w = 3'h0;
    for (int i = 0; i < NSEL; i++) begin
      if (p[i]) w = base_q[i][BIT_FTE] ? FTE_WAITS : {1'b0, mask_q[i][DD_LSB +: DD_W]};
    end
    return w;
  endfunction

  function automatic logic ps_of(input logic [NSEL-1:0] p);
    logic s;
    s = 1'b0;
    for (int i = 0; i < NSEL; i++) begin
      if (p[i]) s = mask_q[i][PS_BIT];
    end
    return s;
  endfunction

  // a cycle cut short by the far side must not leave a count running into the next take
  assign wg_clr = reset_in || cyc_end_in;

  csd_waitgen u_wait (
    .clk_in   (clk_in),
    .reset_in (wg_clr),
    .start_in (start),
    .waits_in (waits_sel),
    .ack_out  (wg_ack)
  );

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      global_q <= 1'b1;
    end else if (base_q[0][BIT_VALID]) begin
      global_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_q      <= CSD_IDLE;
      sel_n_q   <= '1;
      port16_q  <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      unique case (st_q)
        CSD_IDLE: begin
          refused_q <= cyc_in.req && any_refuse;
          if (start) begin
            st_q     <= CSD_WAIT;
            sel_n_q  <= ~pick;
            port16_q <= ps16_sel;
          end
        end
        CSD_WAIT: begin
          if (wg_ack) st_q <= CSD_ACK;
          if (cyc_end_in) begin
            st_q    <= CSD_IDLE;
            sel_n_q <= '1;
          end
        end
        CSD_ACK: begin
          st_q <= CSD_DONE;
          if (cyc_end_in) begin
            st_q    <= CSD_IDLE;
            sel_n_q <= '1;
          end
        end
        CSD_DONE: begin
          if (cyc_end_in) begin
            st_q    <= CSD_IDLE;
            sel_n_q <= '1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup && !mapped;
      prdata_q  <= apb_setup ? rd_word : 32'h0000_0000;
    end
  end

  logic ack_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (st_q == CSD_WAIT) && wg_ack && !cyc_end_in;
    end
  end

  assign select_n_out           = sel_n_q;
  assign cycle_ack_internal_out = ack_q;
  assign port16_out             = port16_q;
  assign write_refused_out      = refused_q;
  assign global_mode_out        = global_q;
  assign prdata_out             = prdata_q;
  assign pready_out             = pready_q;
  assign pslverr_out            = pslverr_q;
endmodule // chip_select_decoder

// [verilog/csd_match.sv]
`timescale 1ns/10ps
module csd_match (
  input  wire logic [31:0]  base_in,
  input  wire logic [31:0]  mask_in,
  input  wire csd_pkg::csd_cyc_s cyc_in,
  output logic              hit_out,
  output logic              refuse_out
);
  import csd_pkg::*;
  wire [31:0] addr_cmp;
  wire [2:0]  fc_cmp;
  wire        valid;
  // low byte is never compared: blocks are at least 256 bytes
  assign addr_cmp = ((cyc_in.addr ^ base_in) & ~mask_in) & ~32'h0000_00FF;
  assign fc_cmp   = (cyc_in.fc ^ base_in[FC_LSB +: FC_W]) & ~mask_in[FC_LSB +: FC_W];
  assign valid    = base_in[BIT_VALID];
  assign hit_out  = valid && (addr_cmp == 32'h0000_0000) && (fc_cmp == 3'h0);
  assign refuse_out = hit_out && cyc_in.write && base_in[BIT_WP];
endmodule // csd_match

// [verilog/csd_waitgen.sv]
`timescale 1ns/10ps
module csd_waitgen (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       start_in,
  input  wire logic [2:0] waits_in,
  output logic            ack_out
);
  import csd_pkg::*;
  logic [2:0] cnt_q;
  logic       run_q;
  wire        expire;
  assign expire  = run_q && (cnt_q == 3'h0);
  assign ack_out = expire;
  always_ff @(posedge clk_in) begin
    if (reset_in || expire) begin
      run_q <= 1'b0;
      cnt_q <= 3'h0;
    end else if (start_in) begin
      run_q <= 1'b1;
      cnt_q <= waits_in;
    end else if (run_q) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
endmodule // csd_waitgen
